/* File: hdl/first_port_map.vh */
// Constants for the first general-purpose port: offsets, reset values, field positions
`ifndef FIRST_PORT_MAP_VH
`define FIRST_PORT_MAP_VH
`define PORT_ADDR_W          4
`define PORT_DATA_W          8
`define OFS_PINS             4'h0
`define OFS_DIRECTION        4'h1
`define OFS_CONV_CFG         4'h2
`define OFS_PERIPH_EN        4'h3
`define RST_DIRECTION        6'h3F
`define RST_LATCH            6'h00
`define RST_CONV_CFG         8'h00
`define RST_PERIPH_EN        6'h00
`define PIN_SLOTS            6
`define PIN_MASK_LARGE       6'h3F
`define PIN_MASK_SMALL       6'h1F
`define ANALOG_PINS          6'h2F
`define SYNC_RST_LEVEL       6'h10
`define OPEN_DRAIN_BIT       4
`define CONV_CFG_ALL_DIGITAL 8'h01
`define READ_ZERO            8'h00
`endif

/* File: hdl/pin_sync.v */
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter             WIDTH     = 6,
   parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b0}}
) (
   input  wire             i_clk_sys,
   input  wire             i_reset,
   input  wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         // Idle levels, so no false edge follows reset
         meta_reg <= RST_VALUE;
         sync_reg <= RST_VALUE;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end
   assign o_sync = sync_reg;
endmodule

/* File: hdl/first_gpio_port_direction.v */
// First general-purpose bidirectional port with direction, latch and analog selection
`timescale 1ns/1ps
`include "first_port_map.vh"
module first_gpio_port_direction #(
   parameter PIN_COUNT = 6
) (
   input  wire                     i_clk_sys,
   input  wire                     i_reset,
   input  wire [`PORT_ADDR_W-1:0]  i_addr,
   input  wire [`PORT_DATA_W-1:0]  i_wdata,
   input  wire                     i_wr,
   input  wire                     i_rd,
   output reg  [`PORT_DATA_W-1:0]  o_rdata,
   input  wire [5:0]               i_pin_in,
   output wire [5:0]               o_pin_out,
   output wire [5:0]               o_pin_oe,
   input  wire [5:0]               i_periph_out,
   input  wire [5:0]               i_periph_oe,
   output wire                     o_timer_zero_clock_input,
   output wire [5:0]               o_analog_select
);
   localparam [5:0] PIN_MASK   = (PIN_COUNT >= 6) ? `PIN_MASK_LARGE : `PIN_MASK_SMALL;
   localparam [5:0] ANALOG_RST = `ANALOG_PINS & PIN_MASK;

   // Register state
   reg  [5:0] latch_reg;
   reg  [5:0] direction_reg;
   reg  [7:0] converter_config_second_reg;
   reg  [5:0] periph_en_reg;
   reg  [5:0] analog_reg;
   reg  [7:0] rdata_next;

   // Pin side
   wire [5:0] pins_sync;
   wire [5:0] digital_in;
   wire [5:0] analog_mask;
   wire [5:0] drive_val;
   wire [5:0] drive_en;

   // Bus side
   wire       sel_pins;
   wire       sel_direction;
   wire       sel_conv_cfg;
   wire       sel_periph_en;
   wire       wr_pins;
   wire       wr_direction;
   wire       wr_conv_cfg;
   wire       wr_periph_en;
   wire [5:0] wdata_pins;

   // Address compare shared by the write strobes and the read mux
   function addr_is;
      input [`PORT_ADDR_W-1:0] addr;
      input [`PORT_ADDR_W-1:0] ofs;
      begin
         addr_is = (addr == ofs);
      end
   endfunction

   // Six pin bits placed in an eight-bit read word; top bits read zero
   function [7:0] widen;
      input [5:0] bits;
      begin
         widen = {2'h0, bits};
      end
   endfunction

   // Per-bit choice between peripheral control and port control
   function [5:0] pin_mux;
      input [5:0] own;
      input [5:0] periph;
      input [5:0] port;
      begin
         pin_mux = (own & periph) | (~own & port);
      end
   endfunction

   // Pin 4 is never analog; the all-digital code frees the rest
   function [5:0] analog_of;
      input [7:0] cfg;
      begin
         if (cfg == `CONV_CFG_ALL_DIGITAL)
            analog_of = 6'h00;
         else
            analog_of = `ANALOG_PINS;
      end
   endfunction

   // Open-drain pin idles high, so its sync flops start high as well
   pin_sync #(
      .WIDTH     (`PIN_SLOTS),
      .RST_VALUE (`SYNC_RST_LEVEL)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_async   (i_pin_in),
      .o_sync    (pins_sync)
   );

   assign sel_pins      = addr_is(i_addr, `OFS_PINS);
   assign sel_direction = addr_is(i_addr, `OFS_DIRECTION);
   assign sel_conv_cfg  = addr_is(i_addr, `OFS_CONV_CFG);
   assign sel_periph_en = addr_is(i_addr, `OFS_PERIPH_EN);

   assign wr_pins      = i_wr & sel_pins;
   assign wr_direction = i_wr & sel_direction;
   assign wr_conv_cfg  = i_wr & sel_conv_cfg;
   assign wr_periph_en = i_wr & sel_periph_en;

   // Bits without a pin are dropped before they reach the latch, direction and peripheral-enable registers
   assign wdata_pins = i_wdata[5:0] & PIN_MASK;

   // Core has already read the pins and merged its bits into the word
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         latch_reg <= `RST_LATCH;
      end else if (wr_pins) begin
         latch_reg <= wdata_pins;
      end
   end

   // Absent pins stay inputs, so their drivers can never turn on
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         direction_reg <= `RST_DIRECTION;
      end else if (wr_direction) begin
         direction_reg <= wdata_pins | ~PIN_MASK;
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         converter_config_second_reg <= `RST_CONV_CFG;
      end else if (wr_conv_cfg) begin
         converter_config_second_reg <= i_wdata;
      end
   end

   // Analog map kept in flops, so the select output never glitches
   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         analog_reg <= ANALOG_RST;
      end else if (wr_conv_cfg) begin
         analog_reg <= analog_of(i_wdata) & PIN_MASK;
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         periph_en_reg <= `RST_PERIPH_EN;
      end else if (wr_periph_en) begin
         periph_en_reg <= wdata_pins;
      end
   end

   assign analog_mask     = analog_reg;
   assign o_analog_select = analog_mask;

   // Peripheral takes the pin wherever its own bit is set
   assign drive_val = pin_mux(periph_en_reg, i_periph_out, latch_reg);
   assign drive_en  = pin_mux(periph_en_reg, i_periph_oe, ~direction_reg);

   genvar g;
   generate
      for (g = 0; g < `PIN_SLOTS; g = g + 1) begin : g_pin
         wire present;
         wire own_val;
         wire own_en;
         wire level;

         assign present = PIN_MASK[g];
         assign own_val = drive_val[g];
         assign own_en  = drive_en[g];
         // Analog or absent pins show zero to the core
         assign level          = pins_sync[g] & ~analog_mask[g] & present;
         assign digital_in[g]  = level;

         if (g == `OPEN_DRAIN_BIT) begin : g_od
            // Only pulls low; the high level is left to the board pull-up
            assign o_pin_out[g] = 1'b0;
            assign o_pin_oe[g]  = own_en & ~own_val & present;
         end else begin : g_cmos
            // Push-pull driver while enabled
            assign o_pin_out[g] = own_val & present;
            assign o_pin_oe[g]  = own_en & present;
         end
      end
   endgenerate

   assign o_timer_zero_clock_input = pins_sync[`OPEN_DRAIN_BIT];

   always @* begin
      rdata_next = `READ_ZERO;
      if (sel_pins) begin
         rdata_next = widen(digital_in);
      end else if (sel_direction) begin
         rdata_next = widen(direction_reg & PIN_MASK);
      end else if (sel_conv_cfg) begin
         rdata_next = converter_config_second_reg;
      end else if (sel_periph_en) begin
         rdata_next = widen(periph_en_reg);
      end
   end

   always @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset)
         o_rdata <= `READ_ZERO;
      else if (i_rd)
         o_rdata <= rdata_next;
      else
         o_rdata <= `READ_ZERO;
   end
endmodule

/* File: tb/port_board.sv */
// Board model: pin levels from drivers, pull-up on the open-drain pin
`timescale 1ns/1ps
module port_board (
   input  logic [5:0] i_out,
   input  logic [5:0] i_oe,
   input  logic [5:0] i_ext,
   output logic [5:0] o_lvl
);
   always_comb for (int i = 0; i < 6; i++) o_lvl[i] = i_oe[i] ? i_out[i] : (i == 4 ? 1'b1 : i_ext[i]);
endmodule

/* File: tb/port_chk_assertions.sv */
// Checker for the first general-purpose port
`timescale 1ns/1ps
module port_chk (
   input logic       i_clk_sys,
   input logic       i_reset,
   input logic [3:0] i_addr,
   input logic [7:0] i_wdata,
   input logic       i_wr,
   input logic       i_rd,
   input logic [7:0] o_rdata,
   input logic [5:0] i_pin_in,
   input logic [5:0] o_pin_out,
   input logic [5:0] o_pin_oe,
   input logic       o_timer_zero_clock_input,
   input logic [5:0] o_analog_select
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   sequence s_dir(d); i_wr && i_addr == 4'h1 && i_wdata == d; endsequence
   property p_od; !o_pin_out[4]; endproperty
   a_od: assert property (p_od) else $error("pin4 driven high");
   property p_rst; $past(i_reset) |-> o_pin_oe == 6'h00 && o_analog_select == 6'h2F; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   property p_in; s_dir(8'hFF) |=> o_pin_oe == 6'h00; endproperty
   a_in: assert property (p_in) else $error("driver on for input");
   property p_out; s_dir(8'h00) |=> o_pin_oe[3:0] == 4'hF && o_pin_oe[5]; endproperty
   a_out: assert property (p_out) else $error("driver off for output");
   property p_cfg; i_wr && i_addr == 4'h2 |=> o_analog_select == ($past(i_wdata) == 8'h01 ? 6'h00 : 6'h2F); endproperty
   a_cfg: assert property (p_cfg) else $error("analog select wrong");
   property p_tmr; !$past(i_reset) && !$past(i_reset, 2) |-> o_timer_zero_clock_input == $past(i_pin_in[4], 2); endproperty
   a_tmr: assert property (p_tmr) else $error("timer clock wrong");
   property p_hi; i_rd && i_addr != 4'h2 |=> o_rdata[7:6] == 2'b00; endproperty
   a_hi: assert property (p_hi) else $error("upper bits set");
   property p_rd; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule
bind first_gpio_port_direction port_chk chk_i (.i_clk_sys, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
   .i_pin_in, .o_pin_out, .o_pin_oe, .o_timer_zero_clock_input, .o_analog_select);

/* File: tb/tb_first_gpio_port_direction.sv */
// Bench for the first general-purpose port
`timescale 1ns/1ps
module tb_first_gpio_port_direction;
   logic clk = 0, rst = 1, wr = 0, rd = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00;
   logic [5:0] ext = 6'h2A, lvl, po, oe, asel;
   logic [5:0] pout = 6'h00, poe = 6'h00;
   logic [7:0] rdata;
   logic       tck;
   int mismatches = 0, n_compared = 0;
   always #10 clk = ~clk;
   first_gpio_port_direction uut (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_pin_in(lvl), .o_pin_out(po), .o_pin_oe(oe), .i_periph_out(pout), .i_periph_oe(poe),
      .o_timer_zero_clock_input(tck), .o_analog_select(asel));
   port_board brd (.i_out(po), .i_oe(oe), .i_ext(ext), .o_lvl(lvl));
   task chk(input string n, input logic [7:0] e, s);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task w(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
      @(posedge clk) wr <= 0;
      #1;
   endtask
   task r(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk) begin rd <= 1; addr <= a; end
      @(posedge clk) rd <= 0;
      #1 chk("rdata", e, rdata);
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin #20000; mismatches++; close_out; end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      r(4'h0, 8'h10);
      chk("oe", 8'h00, {2'b00, oe});
      chk("asel", 8'h2F, {2'b00, asel});
      r(4'h1, 8'h3F);
      r(4'hF, 8'h00);
      w(4'h2, 8'h01);
      chk("asel", 8'h00, {2'b00, asel});
      r(4'h0, 8'h3A);
      w(4'h0, 8'h15);
      w(4'h1, 8'h00);
      chk("oe", 8'h2F, {2'b00, oe});
      chk("po", 8'h05, {2'b00, po});
      repeat (3) @(posedge clk);
      r(4'h0, 8'h15);
      chk("tck", 8'h01, {7'h00, tck});
      w(4'h0, 8'h00);
      repeat (3) @(posedge clk);
      #1 chk("tck", 8'h00, {7'h00, tck});
      w(4'h2, 8'h00);
      chk("asel", 8'h2F, {2'b00, asel});
      chk("oe", 8'h3F, {2'b00, oe});
      w(4'h1, 8'hFF);
      repeat (3) @(posedge clk);
      r(4'h0, 8'h10);
      w(4'h3, 8'h11);
      r(4'h3, 8'h11);
      @(posedge clk) begin pout <= 6'h01; poe <= 6'h11; end
      #1 chk("oe", 8'h11, {2'b00, oe});
      chk("po", 8'h01, {2'b00, po});
      repeat (3) @(posedge clk);
      r(4'h0, 8'h00);
      chk("tck", 8'h00, {7'h00, tck});
      @(posedge clk) begin rst <= 1; pout <= 6'h00; poe <= 6'h00; end
      #1 chk("tck", 8'h01, {7'h00, tck});
      chk("asel", 8'h2F, {2'b00, asel});
      repeat (2) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
      r(4'h1, 8'h3F);
      r(4'h0, 8'h10);
      chk("tck", 8'h01, {7'h00, tck});
      close_out;
   end
endmodule
